// [design/tgc_top.sv]
// Top of the timer gate control block: registers, counter and assertions.
`timescale 1ns/100ps
//
// Notes on behaviour
// - Gate control register holds seven documented fields.
// - Polarity bit chooses high or low active gate.
// - Toggle mode flips gate on rising edges of the qualified gate; off clears.
// - Current level bit reads gate regardless of enable.
// - Counter off stops counting, clears toggle flip-flop.
module tgc_top
  import tgc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [TGC_AW-1:0] reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             count_tick,
  input  wire logic             gate_pin,
  input  wire logic             overflow_src,
  input  wire logic             synced_comparator_output,
  output logic      [15:0]      count_value,
  output logic                  gate_event_flag,
  output logic                  irq
);
  tgc_bus_s      bus;
  tgc_gate_cfg_s cfg;
  logic [7:0]    counter_control_reg;
  logic [15:0]   count;
  logic          gate_level;
  logic          go_done;
  logic          pulse_done;
  logic          advance;
  logic          overflow;
  logic [7:0]    gate_control_reg;
  logic [TGC_NIRQ-1:0] irq_status;
  logic [TGC_NIRQ-1:0] irq_enable;
  logic [TGC_NIRQ-1:0] irq_clr;
  logic [TGC_NIRQ-1:0] irq_events;
  logic          irq_w;
  logic          counter_on;
  logic          go_set;

  function automatic logic hit(input logic [TGC_AW-1:0] off, input logic strobe);
    hit = strobe && (bus.addr == off);
  endfunction : hit

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{enable: 1'b0, polarity: 1'b0, toggle: 1'b0, single: 1'b0, source: 2'h0};
    end else if (hit(TGC_OFF_GATE, bus.wr)) begin
      cfg <= '{enable:   bus.wdata[TGC_B_GE],
               polarity: bus.wdata[TGC_B_POL],
               toggle:   bus.wdata[TGC_B_TM],
               single:   bus.wdata[TGC_B_SPM],
               source:   bus.wdata[1:0]};
    end
  end

  assign go_set = hit(TGC_OFF_GATE, bus.wr) && bus.wdata[TGC_B_GO]
                  && bus.wdata[TGC_B_SPM];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_control_reg <= TGC_CTRL_RST;
    end else if (hit(TGC_OFF_CTRL, bus.wr)) begin
      counter_control_reg <= bus.wdata & TGC_CTRL_MASK;
    end
  end

  assign counter_on = counter_control_reg[TGC_B_ON];

  tgc_gate_path u_gate (
    .ref_clk                  (ref_clk),
    .arst_n                   (arst_n),
    .cfg                      (cfg),
    .counter_on               (counter_on),
    .go_set                   (go_set),
    .gate_pin                 (gate_pin),
    .overflow_src             (overflow_src),
    .synced_comparator_output (synced_comparator_output),
    .gate_level               (gate_level),
    .go_done                  (go_done),
    .pulse_done               (pulse_done)
  );

  // Gate enable has no effect unless the counter is on.
  assign advance  = counter_on && count_tick && (!cfg.enable || gate_level);
  assign overflow = advance && (count == 16'hFFFF);

  // A byte write wins over a count in the same cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= TGC_CNT_RST;
    end else if (hit(TGC_OFF_CNT_HI, bus.wr)) begin
      count <= {bus.wdata, count[7:0]};
    end else if (hit(TGC_OFF_CNT_LO, bus.wr)) begin
      count <= {count[15:8], bus.wdata};
    end else if (advance) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_value <= TGC_CNT_RST;
    end else begin
      count_value <= count;
    end
  end

  assign gate_control_reg = {cfg.enable, cfg.polarity, cfg.toggle, cfg.single,
                             go_done, gate_level, cfg.source};

  assign irq_events = {overflow, pulse_done};
  assign irq_clr    = hit(TGC_OFF_IRQ_CLR, bus.wr) ? bus.wdata[TGC_NIRQ-1:0] : '0;

  tgc_irq #(.N(TGC_NIRQ)) u_irq (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .event_in (irq_events),
    .clr      (irq_clr),
    .en_wdata (bus.wdata[TGC_NIRQ-1:0]),
    .en_wr    (hit(TGC_OFF_IRQ_EN, bus.wr)),
    .status   (irq_status),
    .enable   (irq_enable),
    .irq      (irq_w)
  );

  assign irq = irq_w;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_event_flag <= 1'b0;
    end else begin
      gate_event_flag <= pulse_done;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        TGC_OFF_GATE:     reg_rdata <= gate_control_reg;
        TGC_OFF_CTRL:     reg_rdata <= counter_control_reg;
        TGC_OFF_CNT_HI:   reg_rdata <= count[15:8];
        TGC_OFF_CNT_LO:   reg_rdata <= count[7:0];
        TGC_OFF_IRQ_STAT: reg_rdata <= {6'h00, irq_status};
        TGC_OFF_IRQ_EN:   reg_rdata <= {6'h00, irq_enable};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Assertions.
  // Bus decodes are written out so that the address is a sampled value as well.
  hold_when_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!counter_on && !bus.wr) |=> $stable(count))
    else $error("count moved while counter off");

  gated_stop_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (counter_on && cfg.enable && !gate_level && !bus.wr) |=> $stable(count))
    else $error("count moved with gate inactive");

  gated_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (counter_on && cfg.enable && gate_level && count_tick && !bus.wr)
    |=> count == $past(count) + 16'h0001)
    else $error("count did not step with gate active");

  ungated_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (counter_on && !cfg.enable && count_tick && !bus.wr)
    |=> count == $past(count) + 16'h0001)
    else $error("count did not step with gating off");

  tick_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!count_tick && !bus.wr) |=> $stable(count))
    else $error("count moved without a tick");

  polarity_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cfg.toggle && !cfg.single && cfg.source == TGC_SRC_PIN)
    |-> gate_level == (cfg.polarity ? gate_pin : !gate_pin))
    else $error("gate level ignores polarity");

  pol_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (counter_on && cfg.enable && !cfg.toggle && !cfg.single && !cfg.polarity
     && cfg.source == TGC_SRC_PIN && gate_pin && count_tick && !bus.wr)
    |=> $stable(count))
    else $error("count moved with low-active gate high");

  pol_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (counter_on && cfg.enable && !cfg.toggle && !cfg.single && cfg.polarity
     && cfg.source == TGC_SRC_PIN && !gate_pin && count_tick && !bus.wr)
    |=> $stable(count))
    else $error("count moved with high-active gate low");

  toggle_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cfg.toggle && !cfg.single) ##1 (cfg.toggle && !cfg.single && counter_on)
    |-> !gate_level)
    else $error("toggle flip-flop not cleared");

  toggle_flip_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (counter_on && cfg.toggle && !cfg.single && cfg.polarity
     && cfg.source == TGC_SRC_PIN && !bus.wr)
    ##1 (gate_pin && !$past(gate_pin) && !bus.wr)
    |=> gate_level != $past(gate_level))
    else $error("toggle flip-flop missed a gate edge");

  toggle_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!counter_on && cfg.toggle && !cfg.single && !bus.wr)
    |=> !gate_level)
    else $error("toggle flip-flop kept while counter off");

  level_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.rd && bus.addr == TGC_OFF_GATE)
    |=> reg_rdata[TGC_B_VAL] == $past(gate_level))
    else $error("current level read wrong");

  level_no_enable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cfg.enable && !cfg.toggle && !cfg.single && cfg.source == TGC_SRC_PIN)
    |-> gate_level == (cfg.polarity ? gate_pin : !gate_pin))
    else $error("gate level depends on gate enable");

  rsvd_source_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cfg.toggle && !cfg.single && cfg.source == TGC_SRC_RSVD)
    |-> gate_level == !cfg.polarity)
    else $error("reserved source not a constant low gate");

  cmp_source_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cfg.toggle && !cfg.single && cfg.source == TGC_SRC_CMP)
    |-> gate_level == (cfg.polarity ? synced_comparator_output
                                    : !synced_comparator_output))
    else $error("comparator source not followed");

  ovf_source_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cfg.toggle && !cfg.single && cfg.source == TGC_SRC_TMR0)
    |-> gate_level == (cfg.polarity ? overflow_src : !overflow_src))
    else $error("overflow source not followed");

  byte_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.wr && bus.addr == TGC_OFF_CNT_HI)
    |=> count[15:8] == $past(bus.wdata))
    else $error("high byte write lost");

  low_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.wr && bus.addr == TGC_OFF_CNT_LO)
    |=> count[7:0] == $past(bus.wdata))
    else $error("low byte write lost");

  high_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.rd && bus.addr == TGC_OFF_CNT_HI)
    |=> reg_rdata == $past(count[15:8]))
    else $error("high byte read wrong");

  low_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.rd && bus.addr == TGC_OFF_CNT_LO)
    |=> reg_rdata == $past(count[7:0]))
    else $error("low byte read wrong");

  count_copy_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> count_value == $past(count))
    else $error("count output does not follow count");

  cfg_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.wr && bus.addr == TGC_OFF_GATE)
    |=> (gate_control_reg[7:4] == $past(bus.wdata[7:4])
    && gate_control_reg[1:0] == $past(bus.wdata[1:0])))
    else $error("gate control fields not stored");

  go_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (go_set && !go_done) |=> go_done)
    else $error("go write did not start acquisition");

  done_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.rd && bus.addr == TGC_OFF_GATE)
    |=> reg_rdata[TGC_B_GO] == $past(go_done))
    else $error("go done bit read wrong");

  done_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pulse_done |=> (!go_done && gate_event_flag))
    else $error("acquisition end not reported");

  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus.wr && bus.addr == TGC_OFF_CTRL)
    |=> counter_on == $past(bus.wdata[TGC_B_ON]))
    else $error("counter on bit not stored");
endmodule : tgc_top

// [design/tgc_pkg.sv]
// Package with register map, field positions and types for the timer gate control block.
package tgc_pkg;
  localparam int          TGC_AW           = 3;
  localparam logic [2:0]  TGC_OFF_GATE     = 3'h0;
  localparam logic [2:0]  TGC_OFF_CTRL     = 3'h1;
  localparam logic [2:0]  TGC_OFF_CNT_HI   = 3'h2;
  localparam logic [2:0]  TGC_OFF_CNT_LO   = 3'h3;
  localparam logic [2:0]  TGC_OFF_IRQ_STAT = 3'h4;
  localparam logic [2:0]  TGC_OFF_IRQ_EN   = 3'h5;
  localparam logic [2:0]  TGC_OFF_IRQ_CLR  = 3'h6;
  localparam int          TGC_B_GE         = 7;
  localparam int          TGC_B_POL        = 6;
  localparam int          TGC_B_TM         = 5;
  localparam int          TGC_B_SPM        = 4;
  localparam int          TGC_B_GO         = 3;
  localparam int          TGC_B_VAL        = 2;
  localparam int          TGC_B_ON         = 0;
  localparam logic [1:0]  TGC_SRC_PIN      = 2'h0;
  localparam logic [1:0]  TGC_SRC_TMR0     = 2'h1;
  localparam logic [1:0]  TGC_SRC_CMP      = 2'h2;
  localparam logic [1:0]  TGC_SRC_RSVD     = 2'h3;
  localparam logic [7:0]  TGC_GATE_RST     = 8'h00;
  localparam logic [7:0]  TGC_CTRL_RST     = 8'h00;
  localparam logic [7:0]  TGC_CTRL_MASK    = 8'hFD;
  localparam logic [15:0] TGC_CNT_RST      = 16'h0000;
  localparam int          TGC_NIRQ         = 2;
  localparam int          TGC_IRQ_GATE     = 0;
  localparam int          TGC_IRQ_OVF      = 1;

  typedef struct packed {
    logic [TGC_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } tgc_bus_s;

  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic       toggle;
    logic       single;
    logic [1:0] source;
  } tgc_gate_cfg_s;
endpackage : tgc_pkg

// [design/tgc_gate_path.sv]
// Gate path: source select, polarity, toggle flip-flop and single-pulse sequencing.
`timescale 1ns/100ps
module tgc_gate_path
  import tgc_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  tgc_pkg::tgc_gate_cfg_s cfg,
  input  wire logic          counter_on,
  input  wire logic          go_set,
  input  wire logic          gate_pin,
  input  wire logic          overflow_src,
  input  wire logic          synced_comparator_output,
  output logic               gate_level,
  output logic               go_done,
  output logic               pulse_done
);
  logic src_raw;
  logic pol_gate;
  logic pol_prev;
  logic tff;
  logic tm_gate;
  logic tm_prev;
  logic sp_armed;

  always_comb begin
    unique case (cfg.source)
      TGC_SRC_PIN:  src_raw = gate_pin;
      TGC_SRC_TMR0: src_raw = overflow_src;
      TGC_SRC_CMP:  src_raw = synced_comparator_output;
      TGC_SRC_RSVD: src_raw = 1'b0;
    endcase
  end

  // Invert an active-low gate so that one means count.
  assign pol_gate = cfg.polarity ? src_raw : ~src_raw;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pol_prev <= 1'b0;
    end else begin
      pol_prev <= pol_gate;
    end
  end

  // Toggle flip-flop advances on each rising edge of the qualified gate.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tff <= 1'b0;
    end else if (!cfg.toggle || !counter_on) begin
      tff <= 1'b0;
    end else if (pol_gate && !pol_prev) begin
      tff <= ~tff;
    end
  end

  assign tm_gate = cfg.toggle ? tff : pol_gate;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tm_prev <= 1'b0;
    end else begin
      tm_prev <= tm_gate;
    end
  end

  // Single pulse: after go, wait for a gate rise, count through it, clear go on its fall.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      go_done  <= 1'b0;
      sp_armed <= 1'b0;
    end else if (go_set && !go_done) begin
      // The go write carries single-pulse mode, which cfg only shows one cycle later.
      go_done  <= 1'b1;
      sp_armed <= 1'b0;
    end else if (!cfg.single) begin
      go_done  <= 1'b0;
      sp_armed <= 1'b0;
    end else if (go_done && !sp_armed && tm_gate && !tm_prev) begin
      sp_armed <= 1'b1;
    end else if (go_done && sp_armed && !tm_gate) begin
      go_done  <= 1'b0;
      sp_armed <= 1'b0;
    end
  end

  assign pulse_done = cfg.single && go_done && sp_armed && !tm_gate;

  // The level is reported whether or not gating is enabled.
  assign gate_level = cfg.single ? (tm_gate && go_done && (sp_armed || !tm_prev))
                                 : tm_gate;
endmodule : tgc_gate_path

// [design/tgc_irq.sv]
// Sticky interrupt status with enable and write-one-to-clear.
`timescale 1ns/100ps
module tgc_irq #(
  parameter int N = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] clr,
  input  wire logic [N-1:0] en_wdata,
  input  wire logic         en_wr,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | event_in;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable <= '0;
    end else if (en_wr) begin
      enable <= en_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((status & ~clr) | event_in)) & (en_wr ? en_wdata : enable));
    end
  end
endmodule : tgc_irq

// [verif/tgc_gate_model.sv]
// Behavioural model of the gate sources that feed the timer gate block.
`timescale 1ns/100ps
module tgc_gate_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       level,
  input  wire logic [1:0] src,
  output logic            gate_pin,
  output logic            overflow_src,
  output logic            synced_comparator_output
);
  logic noise;

  // Sources that are not selected change every cycle, so a wrong select shows.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      noise <= 1'b0;
      gate_pin <= 1'b0;
      overflow_src <= 1'b0;
      synced_comparator_output <= 1'b0;
    end else begin
      noise <= !noise;
      gate_pin <= (src == 2'h0) ? level : noise;
      overflow_src <= (src == 2'h1) ? level : !noise;
      synced_comparator_output <= (src == 2'h2) ? level : noise;
    end
  end
endmodule : tgc_gate_model

// [verif/testbench.sv]
// Self-checking testbench for the timer gate control block.
`timescale 1ns/100ps
module testbench;
  import tgc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [TGC_AW-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic count_tick = 1'b0;
  logic gate_pin, overflow_src, synced_comparator_output;
  logic [15:0] count_value;
  logic gate_event_flag, irq;
  logic mdl_level = 1'b0;
  logic [1:0] mdl_src = 2'h0;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int flag_cnt = 0;
  int seed = 32'h7D04;

  tgc_top u_tgc_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_tick(count_tick), .gate_pin(gate_pin), .overflow_src(overflow_src),
    .synced_comparator_output(synced_comparator_output), .count_value(count_value),
    .gate_event_flag(gate_event_flag), .irq(irq));

  tgc_gate_model u_tgc_gate_model (.ref_clk(ref_clk), .arst_n(arst_n), .level(mdl_level),
    .src(mdl_src), .gate_pin(gate_pin), .overflow_src(overflow_src),
    .synced_comparator_output(synced_comparator_output));

  initial begin
    forever #2.5 ref_clk = !ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks++;
    if (seen !== expv) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Read data stand only in the cycle after the read strobe.
  always @(posedge ref_clk) begin
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    if (gate_event_flag === 1'b1) flag_cnt++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic pulse();
    mdl_level <= 1'b1;
    idle(4);
    mdl_level <= 1'b0;
    idle(6);
  endtask : pulse

  task automatic run_case(input logic ge, input logic on, input logic pol, input logic lvl,
                          input logic [1:0] s);
    int n;
    logic [15:0] start;
    logic act;
    logic [15:0] e;
    n = 1 + ($random(seed) & 7);
    start = {13'h1FFF, 3'($random(seed))};
    act = pol ? (lvl && s != 2'h3) : !(lvl && s != 2'h3);
    wr(TGC_OFF_CTRL, 8'h00);
    wr(TGC_OFF_CNT_HI, start[15:8]);
    wr(TGC_OFF_CNT_LO, start[7:0]);
    wr(TGC_OFF_GATE, {ge, pol, 4'h0, s});
    mdl_level <= lvl;
    mdl_src <= s;
    wr(TGC_OFF_CTRL, {7'h00, on});
    idle(6);
    count_tick <= 1'b1;
    idle(n);
    count_tick <= 1'b0;
    idle(4);
    e = (on && (!ge || act)) ? start + 16'(n) : start;
    check(count_value[15:8], e[15:8]);
    check(count_value[7:0], e[7:0]);
    rd(TGC_OFF_CNT_HI, e[15:8]);
    rd(TGC_OFF_CNT_LO, e[7:0]);
    rd(TGC_OFF_GATE, {ge, pol, 3'h0, act, s});
  endtask : run_case

  initial begin
    idle(4);
    arst_n <= 1'b1;
    for (int a = 1; a < 7; a++) rd(3'(a), 8'h00);
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 2; p++)
        for (int l = 0; l < 2; l++) run_case(1'b1, 1'b1, 1'(p), 1'(l), 2'(s));
    run_case(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    run_case(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
    $display("test gating done");
    // The last gating case left the gate high; drop it so the first pulse is an edge.
    mdl_level <= 1'b0;
    wr(TGC_OFF_CTRL, 8'h01);
    wr(TGC_OFF_GATE, 8'hE0);
    pulse();
    rd(TGC_OFF_GATE, 8'hE4);
    pulse();
    rd(TGC_OFF_GATE, 8'hE0);
    pulse();
    wr(TGC_OFF_GATE, 8'hC0);
    wr(TGC_OFF_GATE, 8'hE0);
    rd(TGC_OFF_GATE, 8'hE0);
    pulse();
    wr(TGC_OFF_CTRL, 8'h00);
    wr(TGC_OFF_CTRL, 8'h01);
    rd(TGC_OFF_GATE, 8'hE0);
    $display("test toggle done");
    wr(TGC_OFF_IRQ_CLR, 8'h03);
    wr(TGC_OFF_IRQ_EN, 8'h01);
    wr(TGC_OFF_GATE, 8'hD8);
    rd(TGC_OFF_GATE, 8'hD8);
    pulse();
    rd(TGC_OFF_GATE, 8'hD0);
    rd(TGC_OFF_IRQ_STAT, 8'h01);
    #1 check({7'h00, irq}, 8'h01);
    check(8'(flag_cnt), 8'h01);
    wr(TGC_OFF_IRQ_CLR, 8'h01);
    idle(2);
    #1 check({7'h00, irq}, 8'h00);
    wr(TGC_OFF_IRQ_EN, 8'h00);
    wr(TGC_OFF_GATE, 8'hD8);
    pulse();
    rd(TGC_OFF_IRQ_STAT, 8'h01);
    #1 check({7'h00, irq}, 8'h00);
    check(8'(flag_cnt), 8'h02);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(TGC_OFF_IRQ_STAT, 8'hFF);
    rd(TGC_OFF_IRQ_STAT, 8'h01);
    rd(TGC_OFF_IRQ_CLR, 8'h00);
    idle(3);
    $display("test single pulse done");
    give_verdict();
  end
endmodule : testbench
